// File: rtl/dstc_map.svh
// Purpose: constants of the dual source transfer controller
// Assumes: rms and deviation in 0.1 V units, phase in 0.1 degree units
// Notes: switch inputs read high when the switch is ON
`ifndef DSTC_MAP_SVH
`define DSTC_MAP_SVH
`define DSTC_CLK_HZ 100000000
`define DSTC_TICK_US 1000
`define DSTC_TICK_CYCLES (`DSTC_CLK_HZ / 1000000 * `DSTC_TICK_US)
`define DSTC_MS_TO_TICKS(ms) ((ms) * 1000 / `DSTC_TICK_US)
`define DSTC_HOLD_MS 1000
`define DSTC_STABLE_MS 5000
`define DSTC_DEBOUNCE_MS 20
`define DSTC_ZC_WAIT_MS 20
`define DSTC_DELAY_SHORT_MS 10
`define DSTC_DELAY_LONG_MS 20
`define DSTC_VNOM_110 6'h3f
`define DSTC_VNOM_115 6'h15
`define DSTC_VNOM_120 6'h00
`define DSTC_V110_LO 12'h3de
`define DSTC_V110_HI 12'h4ba
`define DSTC_V115_LO 12'h40b
`define DSTC_V115_HI 12'h4f1
`define DSTC_V120_LO 12'h438
`define DSTC_V120_HI 12'h528
`define DSTC_INST_ERR_MAX 12'h0c8
`define DSTC_FREQ_50 3'h7
`define DSTC_FREQ_60 3'h0
`define DSTC_TOLSW_15 2'h0
`define DSTC_TOLSW_10 2'h1
`define DSTC_TOLSW_7P5 2'h3
`define DSTC_TOL_15 11'h096
`define DSTC_TOL_10 11'h064
`define DSTC_TOL_7P5 11'h04b
`define DSTC_DLYSW_LONG 4'hc
`define DSTC_DLYSW_SHORT 4'hf
`define DSTC_FB_OPEN 2'h0
`define DSTC_FB_FIRST 2'h2
`define DSTC_FB_SECOND 2'h1
`define DSTC_FB_ILLEGAL 2'h3
`endif

// File: rtl/dstc_pkg.sv
// Purpose: shared types of the dual source transfer controller
// Assumes: nothing
// Notes: state of the switch sequencer
package dstc_pkg;
  typedef enum logic [1:0] {
    DSTC_OPEN,
    DSTC_FEED_FIRST,
    DSTC_FEED_SECOND,
    DSTC_GAP
  } dstc_state_t;
endpackage : dstc_pkg

// File: rtl/dstc_sync.sv
// Purpose: three stage synchroniser for pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module dstc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  wire [WIDTH-1:0] syncNext;

  if (WIDTH < 1) begin : g_bad
    $error("dstc_sync: WIDTH must be at least 1");
  end

  assign syncNext = (stage2_reg & stage3_reg) |
                    (syncOut & (stage2_reg ^ stage3_reg));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      syncOut <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      syncOut <= syncNext;
    end
  end
endmodule : dstc_sync

// File: rtl/dstc_hold.sv
// Purpose: debounce of the priority button and press-and-hold timing
// Assumes: buttonLevel already synchronised, tick is a 1 ms pulse
// Notes: one pulse per press; the button must be released to rearm
`timescale 1ns/1ps
`include "dstc_map.svh"
module dstc_hold #(
  parameter int unsigned DEBOUNCE_TICKS = `DSTC_MS_TO_TICKS(`DSTC_DEBOUNCE_MS),
  parameter int unsigned HOLD_TICKS = `DSTC_MS_TO_TICKS(`DSTC_HOLD_MS)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic buttonLevel,
  output logic holdPulse
);
  localparam int DEB_W = $clog2(DEBOUNCE_TICKS + 1);
  localparam int HOLD_W = $clog2(HOLD_TICKS + 1);
  logic debLevel_reg;
  logic [DEB_W-1:0] debCnt_reg;
  logic [HOLD_W-1:0] holdCnt_reg;
  logic fired_reg;
  wire debFlip;
  wire holdDone;

  if (DEBOUNCE_TICKS < 1 || HOLD_TICKS < 2) begin : g_bad
    $error("dstc_hold: debounce and hold counts too small");
  end

  // bounce restarts the count, so only a settled level flips
  assign debFlip = tick && debCnt_reg == DEB_W'(DEBOUNCE_TICKS - 1);
  assign holdDone = tick && !fired_reg &&
                    holdCnt_reg == HOLD_W'(HOLD_TICKS);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      debLevel_reg <= 1'b0;
      debCnt_reg <= '0;
    end else if (buttonLevel == debLevel_reg) begin
      debCnt_reg <= '0;
    end else if (debFlip) begin
      debLevel_reg <= buttonLevel;
      debCnt_reg <= '0;
    end else if (tick) begin
      debCnt_reg <= debCnt_reg + DEB_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !debLevel_reg) begin
      holdCnt_reg <= '0;
      fired_reg <= 1'b0;
      holdPulse <= 1'b0;
    end else begin
      holdPulse <= holdDone;
      if (holdDone) begin
        fired_reg <= 1'b1;
      end else if (tick && !fired_reg) begin
        holdCnt_reg <= holdCnt_reg + HOLD_W'(1);
      end
    end
  end

  a_hold_length: assert property (@(posedge sys_clk) disable iff (rst)
    holdPulse |-> debLevel_reg && holdCnt_reg == HOLD_W'(HOLD_TICKS))
    else $error("hold pulse before full hold time");
endmodule : dstc_hold

// File: rtl/dstc_ctrl.sv
// Purpose: transfer control of a two source single phase static switch
// Assumes: measurement logic on sys_clk supplies rms, deviation, phase
// Notes: switch, button and zero cross pins are synchronised here
`timescale 1ns/1ps
`include "dstc_map.svh"
module dstc_ctrl
  import dstc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DSTC_TICK_CYCLES,
  parameter int unsigned STABLE_TICKS = `DSTC_MS_TO_TICKS(`DSTC_STABLE_MS),
  parameter int unsigned HOLD_TICKS = `DSTC_MS_TO_TICKS(`DSTC_HOLD_MS),
  parameter int unsigned DEBOUNCE_TICKS =
    `DSTC_MS_TO_TICKS(`DSTC_DEBOUNCE_MS)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prioButton,
  input wire logic [5:0] voltSwitches,
  input wire logic [2:0] freqSwitches,
  input wire logic [1:0] phaseTolSwitches,
  input wire logic [3:0] delaySwitches,
  input wire logic [1:0] fallbackSwitches,
  input wire logic loadZeroCross,
  input wire logic [11:0] firstRms,
  input wire logic [11:0] firstInstErr,
  input wire logic [11:0] secondRms,
  input wire logic [11:0] secondInstErr,
  input wire logic [10:0] phaseDiff,
  output logic firstSwitchOn,
  output logic secondSwitchOn,
  output logic firstPriorityLed,
  output logic secondPriorityLed,
  output logic firstInTol,
  output logic secondInTol,
  output logic sourcesInSync,
  output logic mains50Hz,
  output logic configFault
);
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int STB_W = $clog2(STABLE_TICKS + 1);
  localparam logic [4:0] DLY_SHORT =
    5'(`DSTC_MS_TO_TICKS(`DSTC_DELAY_SHORT_MS));
  localparam logic [4:0] DLY_LONG = 5'(`DSTC_MS_TO_TICKS(`DSTC_DELAY_LONG_MS));
  localparam logic [4:0] ZC_WAIT = 5'(`DSTC_MS_TO_TICKS(`DSTC_ZC_WAIT_MS));

  if (TICK_CYCLES < 2 || STABLE_TICKS < 1 || STABLE_TICKS > 65535)
  begin : g_bad
    $error("dstc_ctrl: tick or stable count out of range");
  end

  // synchronised pins
  wire [18:0] pinSync;
  wire buttonSync;
  wire zeroSync;
  wire [5:0] voltSel;
  wire [2:0] freqSel;
  wire [1:0] tolSel;
  wire [3:0] dlySel;
  wire [1:0] fbSel;
  wire holdPulse;

  dstc_sync #(.WIDTH(19)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn({prioButton, loadZeroCross, voltSwitches, freqSwitches,
            phaseTolSwitches, delaySwitches, fallbackSwitches}),
    .syncOut(pinSync)
  );
  assign {buttonSync, zeroSync, voltSel, freqSel, tolSel, dlySel, fbSel} =
    pinSync;

  // 1 ms enable
  logic [TICK_W-1:0] tickCnt_reg;
  logic tick_reg;
  always_ff @(posedge sys_clk) begin
    if (rst || tickCnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tickCnt_reg <= '0;
    end else begin
      tickCnt_reg <= tickCnt_reg + TICK_W'(1);
    end
  end
  always_ff @(posedge sys_clk) begin
    tick_reg <= !rst && tickCnt_reg == TICK_W'(TICK_CYCLES - 1);
  end

  dstc_hold #(
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS),
    .HOLD_TICKS(HOLD_TICKS)
  ) u_hold (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick_reg),
    .buttonLevel(buttonSync),
    .holdPulse(holdPulse)
  );

  // configuration decode; unknown patterns fall back to a safe value
  wire volt110 = voltSel == `DSTC_VNOM_110;
  wire volt115 = voltSel == `DSTC_VNOM_115;
  wire volt120 = voltSel == `DSTC_VNOM_120;
  wire [11:0] vLo = volt110 ? `DSTC_V110_LO :
                    volt115 ? `DSTC_V115_LO : `DSTC_V120_LO;
  wire [11:0] vHi = volt110 ? `DSTC_V110_HI :
                    volt115 ? `DSTC_V115_HI : `DSTC_V120_HI;
  wire freq50 = freqSel == `DSTC_FREQ_50;
  wire freq60 = freqSel == `DSTC_FREQ_60;
  // tolerance is in degrees, so the same figure serves 60 Hz as well
  wire [10:0] phaseTol = tolSel == `DSTC_TOLSW_15 ? `DSTC_TOL_15 :
                         tolSel == `DSTC_TOLSW_7P5 ? `DSTC_TOL_7P5 :
                         `DSTC_TOL_10;
  wire tolBad = !(tolSel == `DSTC_TOLSW_15 || tolSel == `DSTC_TOLSW_10 ||
                  tolSel == `DSTC_TOLSW_7P5);
  wire dlyZero = dlySel[3:2] == 2'h0;
  wire [4:0] oosTicks = dlyZero ? 5'h00 :
                        dlySel == `DSTC_DLYSW_LONG ? DLY_LONG :
                        DLY_SHORT;
  wire fbIllegal = fbSel == `DSTC_FB_ILLEGAL;
  wire fbFirst = fbSel == `DSTC_FB_FIRST;
  wire fbSecond = fbSel == `DSTC_FB_SECOND;
  wire cfgBad = !(volt110 || volt115 || volt120) || !(freq50 || freq60) ||
                tolBad || fbIllegal;

  // per source acceptance window and stability timer
  wire [11:0] srcRms [2];
  wire [11:0] srcErr [2];
  wire [1:0] inWin;
  wire [1:0] stableGood;
  logic [STB_W-1:0] stableCnt_reg [2];
  logic [1:0] inTol_reg;
  assign srcRms[0] = firstRms;
  assign srcRms[1] = secondRms;
  assign srcErr[0] = firstInstErr;
  assign srcErr[1] = secondInstErr;

  for (genvar s = 0; s < 2; s++) begin : g_src
    assign inWin[s] = srcRms[s] >= vLo && srcRms[s] <= vHi &&
                      srcErr[s] <= `DSTC_INST_ERR_MAX;
    assign stableGood[s] = stableCnt_reg[s] == STB_W'(STABLE_TICKS);
    always_ff @(posedge sys_clk) begin
      if (rst || !inWin[s]) begin
        stableCnt_reg[s] <= '0;
      end else if (tick_reg && !stableGood[s]) begin
        stableCnt_reg[s] <= stableCnt_reg[s] + STB_W'(1);
      end
    end
    always_ff @(posedge sys_clk) begin
      inTol_reg[s] <= !rst && inWin[s];
    end
  end

  wire syncOk = phaseDiff < phaseTol;

  // priority selection
  logic prioFirst_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prioFirst_reg <= 1'b1;
    end else if (holdPulse) begin
      prioFirst_reg <= !prioFirst_reg;
    end
  end

  // switch sequencer
  dstc_state_t state_reg;
  dstc_state_t state_next;
  logic target_reg;
  logic target_next;
  logic [4:0] gap_reg;
  logic [4:0] gap_next;
  logic [4:0] zcWait_reg;

  wire activeFirst = state_reg == DSTC_FEED_FIRST;
  wire feeding = activeFirst || state_reg == DSTC_FEED_SECOND;
  wire activeOk = activeFirst ? inWin[0] : inWin[1];
  wire otherOk = activeFirst ? inWin[1] : inWin[0];
  wire prioOk = prioFirst_reg ? inWin[0] : inWin[1];
  wire prioStable = prioFirst_reg ? stableGood[0] : stableGood[1];
  wire onPrio = feeding && activeFirst == prioFirst_reg;
  wire retReady = feeding && !onPrio && prioStable && &inWin &&
                  syncOk;
  // without a zero cross in time, transfer anyway rather than stay
  wire zcGo = zeroSync || zcWait_reg >= ZC_WAIT;
  wire fbOther = activeFirst ? fbSecond : fbFirst;
  wire fbOpen = fbIllegal || fbSel == `DSTC_FB_OPEN;

  always_ff @(posedge sys_clk) begin
    if (rst || !retReady) begin
      zcWait_reg <= '0;
    end else if (tick_reg && zcWait_reg < ZC_WAIT) begin
      zcWait_reg <= zcWait_reg + 5'h01;
    end
  end

  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    gap_next = gap_reg;
    case (state_reg)
      DSTC_OPEN: begin
        if (prioOk) begin
          state_next = DSTC_GAP;
          target_next = prioFirst_reg;
          gap_next = 5'h00;
        end else if (|inWin) begin
          state_next = DSTC_GAP;
          target_next = !prioFirst_reg;
          gap_next = 5'h00;
        end else if (fbFirst || fbSecond) begin
          state_next = DSTC_GAP;
          target_next = fbFirst;
          gap_next = 5'h00;
        end
      end
      DSTC_FEED_FIRST, DSTC_FEED_SECOND: begin
        if (!activeOk && otherOk) begin
          state_next = DSTC_GAP;
          target_next = !activeFirst;
          gap_next = syncOk ? 5'h00 : oosTicks;
        end else if (!activeOk && fbOpen) begin
          state_next = DSTC_OPEN;
        end else if (!activeOk && fbOther) begin
          state_next = DSTC_GAP;
          target_next = !activeFirst;
          gap_next = 5'h00;
        end else if (activeOk && retReady && zcGo) begin
          state_next = DSTC_GAP;
          target_next = prioFirst_reg;
          gap_next = 5'h00;
        end
      end
      DSTC_GAP: begin
        // both switches are open for at least this one cycle
        if (gap_reg == 5'h00) begin
          state_next = target_reg ? DSTC_FEED_FIRST : DSTC_FEED_SECOND;
        end else if (tick_reg) begin
          gap_next = gap_reg - 5'h01;
        end
      end
      default: begin
        state_next = DSTC_OPEN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= DSTC_OPEN;
      target_reg <= 1'b1;
      gap_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      gap_reg <= gap_next;
    end
  end

  // outputs, all from flip-flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      firstSwitchOn <= 1'b0;
      secondSwitchOn <= 1'b0;
      firstPriorityLed <= 1'b1;
      secondPriorityLed <= 1'b0;
      sourcesInSync <= 1'b0;
      mains50Hz <= 1'b1;
      configFault <= 1'b0;
    end else begin
      firstSwitchOn <= state_next == DSTC_FEED_FIRST;
      secondSwitchOn <= state_next == DSTC_FEED_SECOND;
      firstPriorityLed <= prioFirst_reg ^ holdPulse;
      secondPriorityLed <= !(prioFirst_reg ^ holdPulse);
      sourcesInSync <= syncOk;
      mains50Hz <= !freq60;
      configFault <= cfgBad;
    end
  end
  assign firstInTol = inTol_reg[0];
  assign secondInTol = inTol_reg[1];

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_open_then_second;
    !firstSwitchOn && !secondSwitchOn ##1 secondSwitchOn;
  endsequence

  a_switch_exclusive: assert property (
    !(firstSwitchOn && secondSwitchOn))
    else $error("both switches closed");
  a_break_before: assert property (secondSwitchOn |=> !firstSwitchOn)
    else $error("first closed straight after second");
  a_led_exclusive: assert property (
    firstPriorityLed != secondPriorityLed)
    else $error("priority indicators not exclusive");
  a_led_toggle: assert property (
    holdPulse |=> firstPriorityLed != $past(firstPriorityLed))
    else $error("held press did not change priority");
  a_reset_prio: assert property ($fell(rst) |-> firstPriorityLed)
    else $error("first source not priority after reset");
  a_fault_move: assert property (
    state_reg == DSTC_FEED_FIRST && !inWin[0] && inWin[1] && syncOk
    |-> ##1 s_open_then_second)
    else $error("no transfer to second on first fault");
  a_oos_delay: assert property (
    state_reg == DSTC_FEED_FIRST && !inWin[0] && inWin[1] && !syncOk &&
    oosTicks != 5'h00 |-> ##1 (!secondSwitchOn) [*3])
    else $error("out of sync transfer not delayed");
  a_return_cond: assert property (
    feeding && activeOk && !onPrio && state_next == DSTC_GAP
    |-> prioStable && syncOk && &inWin)
    else $error("return without stable synchronised sources");
  a_illegal_open: assert property (
    fbIllegal && state_reg != DSTC_GAP && inWin == 2'b00
    |=> !firstSwitchOn && !secondSwitchOn)
    else $error("switch closed with illegal fallback setting");
endmodule : dstc_ctrl

// File: verification/dstc_src_model.sv
// Purpose: two ac sources and a load as seen by the transfer controller
// Assumes: rms set by the bench, ripple and zero cross made here
// Notes: deviation ripple stays inside the 20.0 V limit unless spiked
`timescale 1ns/1ps
module dstc_src_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] firstLevel,
  input wire logic [11:0] secondLevel,
  input wire logic firstSpike,
  input wire logic [10:0] skew,
  output logic [11:0] firstRms,
  output logic [11:0] firstInstErr,
  output logic [11:0] secondRms,
  output logic [11:0] secondInstErr,
  output logic [10:0] phaseDiff,
  output logic loadZeroCross
);
  logic [5:0] phase_reg;
  logic [5:0] phase_next;
  assign phase_next = phase_reg + 6'h01;
  always_ff @(posedge sys_clk) begin
    phase_reg <= rst ? 6'h00 : phase_next;
  end
  // ripple moves every cycle so a stale sample never looks constant
  assign firstInstErr = firstSpike ? 12'h0c9 : {6'h00, phase_reg};
  assign secondInstErr = {6'h00, ~phase_reg};
  assign firstRms = firstLevel;
  assign secondRms = secondLevel;
  assign phaseDiff = skew;
  // load current near zero for 4 of every 64 cycles
  assign loadZeroCross = (phase_reg[5:2] == 4'h0);
endmodule : dstc_src_model

// File: verification/tb.sv
// Purpose: self-checking bench of the transfer controller
// Assumes: short ticks of 10 cycles, hold 4, stable 8, debounce 2
// Notes: both switches closed together is watched on every cycle out of reset
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [5:0] volt; logic [11:0] rms; logic spike; logic [1:0] tol;
    logic [10:0] pd; logic [2:0] freq; logic expTol; logic expSync;
    logic exp50;
  } dstc_row_t;
  localparam int NROWS = 13;
  dstc_row_t rows [NROWS] = '{
    '{6'h3f, 12'h3de, 1'h0, 2'h0, 11'h095, 3'h5, 1'h1, 1'h1, 1'h1},
    '{6'h3f, 12'h3dd, 1'h0, 2'h0, 11'h7ff, 3'h7, 1'h0, 1'h0, 1'h1},
    '{6'h3f, 12'h4ba, 1'h0, 2'h1, 11'h063, 3'h0, 1'h1, 1'h1, 1'h0},
    '{6'h3f, 12'h4bb, 1'h0, 2'h1, 11'h7ff, 3'h0, 1'h0, 1'h0, 1'h0},
    '{6'h15, 12'h40b, 1'h0, 2'h1, 11'h064, 3'h7, 1'h1, 1'h0, 1'h1},
    '{6'h15, 12'h40a, 1'h0, 2'h1, 11'h7ff, 3'h7, 1'h0, 1'h0, 1'h1},
    '{6'h15, 12'h4f1, 1'h0, 2'h3, 11'h04a, 3'h7, 1'h1, 1'h1, 1'h1},
    '{6'h15, 12'h4f2, 1'h0, 2'h3, 11'h7ff, 3'h7, 1'h0, 1'h0, 1'h1},
    '{6'h00, 12'h438, 1'h0, 2'h3, 11'h04b, 3'h0, 1'h1, 1'h0, 1'h0},
    '{6'h00, 12'h437, 1'h0, 2'h3, 11'h7ff, 3'h0, 1'h0, 1'h0, 1'h0},
    '{6'h00, 12'h528, 1'h0, 2'h0, 11'h096, 3'h0, 1'h1, 1'h0, 1'h0},
    '{6'h00, 12'h529, 1'h0, 2'h0, 11'h7ff, 3'h0, 1'h0, 1'h0, 1'h0},
    '{6'h00, 12'h4b0, 1'h1, 2'h0, 11'h7ff, 3'h0, 1'h0, 1'h0, 1'h0}
  };
  logic sys_clk, rst, prioButton, loadZeroCross, firstSpike;
  logic [5:0] voltSwitches;
  logic [2:0] freqSwitches;
  logic [1:0] phaseTolSwitches, fallbackSwitches;
  logic [3:0] delaySwitches;
  logic [11:0] firstLevel, secondLevel, firstRms, firstInstErr;
  logic [11:0] secondRms, secondInstErr;
  logic [10:0] skew, phaseDiff;
  logic firstSwitchOn, secondSwitchOn, firstPriorityLed, secondPriorityLed;
  logic firstInTol, secondInTol, sourcesInSync, mains50Hz, configFault;
  int mismatches = 0;
  int numChecks = 0;
  int n;
  logic [3:0] dly [3] = '{4'h0, 4'hf, 4'hc};
  // gap window in cycles: delay of 0, 10 or 20 ticks, two ticks under to two and a half ticks over
  int dlyLo [3] = '{0, 80, 180};
  int dlyHi [3] = '{25, 125, 225};
  logic [1:0] fb [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  logic [1:0] fbSw [4] = '{2'h2, 2'h1, 2'h0, 2'h0};

  dstc_src_model i_dstc_src_model (.sys_clk(sys_clk), .rst(rst),
    .firstLevel(firstLevel), .secondLevel(secondLevel),
    .firstSpike(firstSpike), .skew(skew), .firstRms(firstRms),
    .firstInstErr(firstInstErr), .secondRms(secondRms),
    .secondInstErr(secondInstErr), .phaseDiff(phaseDiff),
    .loadZeroCross(loadZeroCross));
  dstc_ctrl #(.TICK_CYCLES(10), .STABLE_TICKS(8), .HOLD_TICKS(4),
    .DEBOUNCE_TICKS(2)) i_dstc_ctrl (.sys_clk(sys_clk), .rst(rst),
    .prioButton(prioButton), .voltSwitches(voltSwitches),
    .freqSwitches(freqSwitches), .phaseTolSwitches(phaseTolSwitches),
    .delaySwitches(delaySwitches), .fallbackSwitches(fallbackSwitches),
    .loadZeroCross(loadZeroCross), .firstRms(firstRms),
    .firstInstErr(firstInstErr), .secondRms(secondRms),
    .secondInstErr(secondInstErr), .phaseDiff(phaseDiff),
    .firstSwitchOn(firstSwitchOn), .secondSwitchOn(secondSwitchOn),
    .firstPriorityLed(firstPriorityLed),
    .secondPriorityLed(secondPriorityLed), .firstInTol(firstInTol),
    .secondInTol(secondInTol), .sourcesInSync(sourcesInSync),
    .mains50Hz(mains50Hz), .configFault(configFault));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (mismatches == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // bounded wait for a switch pattern; running out ends the run
  task automatic waitSw(input logic [1:0] want, input int lim);
    n = 0;
    while ({firstSwitchOn, secondSwitchOn} !== want) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        check(12'({firstSwitchOn, secondSwitchOn}), 12'(want));
        summarize();
      end
    end
  endtask : waitSw

  task automatic press(input int len);
    prioButton = 1'b1;
    repeat (len) @(negedge sys_clk);
    prioButton = 1'b0;
    repeat (40) @(negedge sys_clk);
  endtask : press

  always @(negedge sys_clk) begin
    if (rst === 1'b0) begin
      numChecks++;
      if ((firstSwitchOn & secondSwitchOn) !== 1'b0) begin
        mismatches++;
        $display("BAD t=%0t got=%h exp=%h", $time, 2'h3, 2'h0);
      end
    end
  end

  initial begin
    rst = 1'b1; prioButton = 1'b0; voltSwitches = 6'h3f;
    freqSwitches = 3'h7; phaseTolSwitches = 2'h1; delaySwitches = 4'h0;
    fallbackSwitches = 2'h2; firstLevel = 12'h44c; secondLevel = 12'h44c;
    firstSpike = 1'b0; skew = 11'h000;
    repeat (12) @(negedge sys_clk);
    check(12'({firstPriorityLed, secondPriorityLed}), 12'h2);
    rst = 1'b0;
    for (int i = 0; i < NROWS; i++) begin
      voltSwitches = rows[i].volt; firstLevel = rows[i].rms;
      secondLevel = rows[i].rms; firstSpike = rows[i].spike;
      phaseTolSwitches = rows[i].tol; skew = rows[i].pd;
      freqSwitches = rows[i].freq;
      repeat (8) @(negedge sys_clk);
      check(12'(firstInTol), 12'(rows[i].expTol));
      check(12'(secondInTol), 12'(rows[i].expTol | rows[i].spike));
      check(12'(sourcesInSync), 12'(rows[i].expSync));
      check(12'(mains50Hz), 12'(rows[i].exp50));
    end
    voltSwitches = 6'h3f; firstLevel = 12'h44c; secondLevel = 12'h44c;
    firstSpike = 1'b0; phaseTolSwitches = 2'h1; freqSwitches = 3'h7;
    skew = 11'h000;
    for (int i = 0; i < 3; i++) begin
      delaySwitches = dly[i];
      skew = 11'h000;
      waitSw(2'h2, 1000);
      if (i > 0) skew = 11'h700;
      repeat (8) @(negedge sys_clk);
      firstLevel = 12'h000;
      waitSw(2'h1, 400);
      check(12'(n >= dlyLo[i] && n <= dlyHi[i]), 12'h1);
      firstLevel = 12'h44c;
      repeat (60) @(negedge sys_clk);
      check(12'({firstSwitchOn, secondSwitchOn}), 12'h1);
    end
    skew = 11'h000;
    waitSw(2'h2, 600);
    firstLevel = 12'h000;
    secondLevel = 12'h000;
    for (int i = 0; i < 4; i++) begin
      fallbackSwitches = fb[i];
      repeat (300) @(negedge sys_clk);
      check(12'({firstSwitchOn, secondSwitchOn}), 12'(fbSw[i]));
      check(12'(configFault), 12'(i == 3));
    end
    fallbackSwitches = 2'h2; firstLevel = 12'h44c; secondLevel = 12'h44c;
    waitSw(2'h2, 1000);
    // bounce never stays level long enough to pass the debounce
    for (int i = 0; i < 10; i++) begin
      prioButton = 1'b1;
      repeat (3) @(negedge sys_clk);
      prioButton = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    // release debounce keeps the level up two more ticks, so stay well short
    press(30);
    check(12'({firstPriorityLed, secondPriorityLed}), 12'h2);
    press(120);
    check(12'({firstPriorityLed, secondPriorityLed}), 12'h1);
    waitSw(2'h1, 600);
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    check(12'({firstPriorityLed, secondPriorityLed}), 12'h2);
    check(12'({firstSwitchOn, secondSwitchOn}), 12'h0);
    rst = 1'b0;
    waitSw(2'h2, 1000);
    summarize();
  end
endmodule : tb
